// [verilog/mcrg_cfg.svh]
// constants for the memory controller clock and reset generator
// assumes a single 250 MHz SYS_CLK that stands for the pll's fast output
`ifndef MCRG_CFG_SVH
`define MCRG_CFG_SVH

// =====================================
// clock rate
`define MCRG_CLK_PERIOD_NS 4

// =====================================
// pll lock model: least lock time, rounded up to cycles
`define MCRG_LOCK_TIME_NS 10000
`define MCRG_LOCK_CYCLES ((`MCRG_LOCK_TIME_NS + `MCRG_CLK_PERIOD_NS - 1) / `MCRG_CLK_PERIOD_NS)
`define MCRG_LOCK_CNT_W 12

// =====================================
// soft reset hold time on the physical layer, rounded up to cycles
`define MCRG_SOFT_TIME_NS 64
`define MCRG_SOFT_CYCLES ((`MCRG_SOFT_TIME_NS + `MCRG_CLK_PERIOD_NS - 1) / `MCRG_CLK_PERIOD_NS)
`define MCRG_SOFT_CNT_W 5

// =====================================
// reset values
`define MCRG_LOCK_CNT_RST 12'h0000
`define MCRG_SOFT_CNT_RST 5'h00

`endif

// [verilog/mcrg_pkg.sv]
// types shared by the clock and reset generator
// assumes nothing beyond the cfg header
package mcrg_pkg;

	// =====================================
	// pll lock model states
	typedef enum logic [1:0] {
		PLL_RESET,
		PLL_LOCKING,
		PLL_LOCKED
	} mcrg_pll_e;

	// rate mode of the controller
	typedef enum logic {
		RATE_FULL,
		RATE_HALF
	} mcrg_rate_e;

endpackage : mcrg_pkg

// [verilog/mcrg_rst_sync.sv]
// reset synchroniser: asserts asynchronously, releases on the clock
// assumes arst_b may fall at any time and clk runs while it is released
`timescale 1ns/1ns

module mcrg_rst_sync (
	input wire logic clk,
	input wire logic arst_b,
	output logic rst_b
);
	import mcrg_pkg::*;

	logic stage1_ff;
	logic stage2_ff;

	// =====================================
	// two-stage release chain; only stage2 leaves this module
	always_ff @(posedge clk or negedge arst_b) begin
		if (!arst_b) begin
			stage1_ff <= 1'b0;
			stage2_ff <= 1'b0;
		end else begin
			stage1_ff <= 1'b1;
			stage2_ff <= stage1_ff;
		end
	end

	assign rst_b = stage2_ff;

endmodule : mcrg_rst_sync

// [verilog/mcrg_top.sv]
// clock and reset generator for a ddr sdram controller and its physical layer
// assumes SYS_CLK is the pll fast output at memory rate; slower clocks are
// one-cycle enables; SOFT_RST_B and HALF_RATE_MODE come from pins.
`timescale 1ns/1ns
`include "mcrg_cfg.svh"

module mcrg_top #(
	parameter int unsigned LOCK_CYCLES = `MCRG_LOCK_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic SOFT_RST_B,
	input wire logic HALF_RATE_MODE,
	output logic SYS_CLK_EN,
	output logic AUX_FULL_EN,
	output logic AUX_HALF_EN,
	output logic USER_RST_B,
	output logic RESET_REQ_B,
	output mcrg_pkg::mcrg_rate_e RATE_MODE
);
	import mcrg_pkg::*;

	// last count values of the lock timer and the soft reset hold timer
	localparam logic [`MCRG_LOCK_CNT_W-1:0] LOCK_LAST = `MCRG_LOCK_CNT_W'(LOCK_CYCLES - 1);
	localparam logic [`MCRG_SOFT_CNT_W-1:0] SOFT_LAST =
		`MCRG_SOFT_CNT_W'(`MCRG_SOFT_CYCLES - 1);

	// lock model
	mcrg_pll_e pll_state_ff;
	mcrg_pll_e nxt_pll_state;
	logic [`MCRG_LOCK_CNT_W-1:0] lock_cnt_ff;
	logic locked_ff;
	// internal resets and pin synchronisers
	logic glb_rst_b;
	logic [1:0] pin_sync1_ff;
	logic [1:0] pin_sync2_ff;
	logic soft_prev_ff;
	logic soft_fall;
	logic soft_busy_ff;
	logic [`MCRG_SOFT_CNT_W-1:0] soft_cnt_ff;
	logic phy_run_ff;
	logic user_arst_b;
	// rate mode and enable generation
	logic phase_ff;
	mcrg_rate_e rate_ff;
	logic full_en_ff;
	logic half_en_ff;
	logic sys_en_ff;

	// =====================================
	// pll lock model, held in reset straight from the global pin
	always_comb begin
		nxt_pll_state = pll_state_ff;
		unique case (pll_state_ff)
			PLL_RESET: nxt_pll_state = PLL_LOCKING;
			PLL_LOCKING: begin
				if (lock_cnt_ff == LOCK_LAST) begin
					nxt_pll_state = PLL_LOCKED;
				end
			end
			PLL_LOCKED: nxt_pll_state = PLL_LOCKED;
			default: nxt_pll_state = PLL_RESET;
		endcase
	end

	// pll state and lock counter; RST_B acts here directly so the pll
	// stops at once instead of waiting for the resynchronised copy
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pll_state_ff <= PLL_RESET;
			lock_cnt_ff <= `MCRG_LOCK_CNT_RST;
		end else begin
			pll_state_ff <= nxt_pll_state;
			if (pll_state_ff == PLL_LOCKING) begin
				lock_cnt_ff <= lock_cnt_ff + `MCRG_LOCK_CNT_W'(1);
			end
		end
	end

	// lock flag, also the reset request level
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			locked_ff <= 1'b0;
		end else begin
			locked_ff <= (nxt_pll_state == PLL_LOCKED);
		end
	end

	// low from reset until lock; a consumer should act on the falling
	// edge because the level stays low for the whole lock time
	assign RESET_REQ_B = locked_ff;

	// =====================================
	// resynchronised copy of the global reset for all other resets; the user reset gate also takes RST_B directly
	mcrg_rst_sync u_glb_sync (
		.clk(SYS_CLK),
		.arst_b(RST_B),
		.rst_b(glb_rst_b)
	);

	// pin inputs pass two flops before any use
	// reset values equal the idle pin levels so no false soft edge follows
	always_ff @(posedge SYS_CLK or negedge glb_rst_b) begin
		if (!glb_rst_b) begin
			pin_sync1_ff <= 2'h3; // soft reset idle high, half-rate default
			pin_sync2_ff <= 2'h3;
		end else begin
			pin_sync1_ff <= {SOFT_RST_B, HALF_RATE_MODE};
			pin_sync2_ff <= pin_sync1_ff;
		end
	end

	// =====================================
	// soft reset falling-edge detect and phy hold timer
	// a new fall during the hold restarts the timer; the pll never sees it
	assign soft_fall = soft_prev_ff & ~pin_sync2_ff[1];

	always_ff @(posedge SYS_CLK or negedge glb_rst_b) begin
		if (!glb_rst_b) begin
			soft_prev_ff <= 1'b1;
			soft_busy_ff <= 1'b0;
			soft_cnt_ff <= `MCRG_SOFT_CNT_RST;
		end else begin
			soft_prev_ff <= pin_sync2_ff[1];
			if (soft_fall) begin
				soft_busy_ff <= 1'b1;
				soft_cnt_ff <= `MCRG_SOFT_CNT_RST;
			end else if (soft_busy_ff) begin
				soft_cnt_ff <= soft_cnt_ff + `MCRG_SOFT_CNT_W'(1);
				if (soft_cnt_ff == SOFT_LAST) begin
					soft_busy_ff <= 1'b0;
				end
			end
		end
	end

	// phy runs only with lock and no soft reset; pll is untouched by soft reset
	always_ff @(posedge SYS_CLK or negedge glb_rst_b) begin
		if (!glb_rst_b) begin
			phy_run_ff <= 1'b0;
		end else begin
			phy_run_ff <= locked_ff & ~soft_busy_ff & ~soft_fall;
		end
	end

	// =====================================
	// user reset: async assert from flops, synchronous release
	// RST_B in the gate asserts at once, before the internal chain reacts;
	// release always passes the two flops of the synchroniser
	assign user_arst_b = RST_B & phy_run_ff;

	mcrg_rst_sync u_user_sync (
		.clk(SYS_CLK),
		.arst_b(user_arst_b),
		.rst_b(USER_RST_B)
	);

	// =====================================
	// rate mode, taken from the synchronised pin while phy is stopped
	// the pin is ignored while the phy runs so live user logic never sees
	// the enable pattern change under it
	always_ff @(posedge SYS_CLK or negedge glb_rst_b) begin
		if (!glb_rst_b) begin
			rate_ff <= RATE_HALF;
		end else if (!phy_run_ff) begin
			rate_ff <= pin_sync2_ff[0] ? RATE_HALF : RATE_FULL;
		end
	end

	assign RATE_MODE = rate_ff;

	// divider phase for the half-rate enable, runs only once locked
	always_ff @(posedge SYS_CLK or negedge glb_rst_b) begin
		if (!glb_rst_b) begin
			phase_ff <= 1'b0;
		end else if (locked_ff) begin
			phase_ff <= ~phase_ff;
		end else begin
			phase_ff <= 1'b0;
		end
	end

	// =====================================
	// clock enables, registered
	// registered so each enable is clean on SYS_CLK; half-rate enables are one-cycle pulses, AUX_FULL_EN stays high once locked
	always_ff @(posedge SYS_CLK or negedge glb_rst_b) begin
		if (!glb_rst_b) begin
			full_en_ff <= 1'b0;
			half_en_ff <= 1'b0;
			sys_en_ff <= 1'b0;
		end else begin
			full_en_ff <= locked_ff;
			half_en_ff <= locked_ff & phase_ff;
			if (rate_ff == RATE_HALF) begin
				sys_en_ff <= locked_ff & phase_ff;
			end else begin
				sys_en_ff <= locked_ff;
			end
		end
	end

	// outputs straight from the enable flops
	assign AUX_FULL_EN = full_en_ff;
	assign AUX_HALF_EN = half_en_ff;
	assign SYS_CLK_EN = sys_en_ff;

endmodule : mcrg_top

// [tb/mcrg_top_sva.sv]
// port checker for the clock and reset generator
// assumes it is bound onto mcrg_top, one clock domain
`timescale 1ns/1ns
module mcrg_chk (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic SOFT_RST_B,
	input wire logic SYS_CLK_EN,
	input wire logic AUX_FULL_EN,
	input wire logic AUX_HALF_EN,
	input wire logic USER_RST_B,
	input wire logic RESET_REQ_B,
	input wire mcrg_pkg::mcrg_rate_e RATE_MODE
);
	import mcrg_pkg::*;
	// ==========
	// output relations
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	property p_glob; $rose(RST_B) |-> !RESET_REQ_B && !USER_RST_B; endproperty
	a_glob: assert property (p_glob) else $error("outputs up at reset release");
	property p_sync; $rose(RST_B) |-> !USER_RST_B [*4]; endproperty
	a_sync: assert property (p_sync) else $error("user reset not resynchronised");
	property p_rel; $rose(USER_RST_B) |-> $past(RESET_REQ_B, 2); endproperty
	a_rel: assert property (p_rel) else $error("user reset freed before lock");
	property p_req; !RESET_REQ_B |-> !USER_RST_B; endproperty
	a_req: assert property (p_req) else $error("user reset high while unlocked");
	property p_full; RESET_REQ_B && $past(RESET_REQ_B, 3) |-> AUX_FULL_EN; endproperty
	a_full: assert property (p_full) else $error("full rate enable missing");
	property p_half; RESET_REQ_B [*4] |-> AUX_HALF_EN != $past(AUX_HALF_EN); endproperty
	a_half: assert property (p_half) else $error("half rate enable not alternating");
	property p_hm; USER_RST_B && RATE_MODE == RATE_HALF |-> SYS_CLK_EN == AUX_HALF_EN;
	endproperty
	a_hm: assert property (p_hm) else $error("half mode system enable wrong");
	property p_fm; USER_RST_B && RATE_MODE == RATE_FULL |-> SYS_CLK_EN == AUX_FULL_EN;
	endproperty
	a_fm: assert property (p_fm) else $error("full mode system enable wrong");
	property p_soft; $fell(SOFT_RST_B) && USER_RST_B |-> ##[1:6] !USER_RST_B; endproperty
	a_soft: assert property (p_soft) else $error("soft reset not taken");
	property p_pll; $fell(USER_RST_B) |-> (RESET_REQ_B && !USER_RST_B) [*8]; endproperty
	a_pll: assert property (p_pll) else $error("soft reset hit pll or too short");
endmodule : mcrg_chk
bind mcrg_top mcrg_chk u_chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .SOFT_RST_B(SOFT_RST_B),
	.SYS_CLK_EN(SYS_CLK_EN), .AUX_FULL_EN(AUX_FULL_EN), .AUX_HALF_EN(AUX_HALF_EN),
	.USER_RST_B(USER_RST_B), .RESET_REQ_B(RESET_REQ_B), .RATE_MODE(RATE_MODE));

// [tb/mcrg_sys_rst_ctl.sv]
// system reset controller model: counts reset requests
// assumes req_b is the active-low request, clk the system clock
`timescale 1ns/1ns
module mcrg_sys_rst_ctl (
	input wire logic clk,
	input wire logic req_b,
	output logic [3:0] req_cnt
);
	logic prev_ff = 1'b1;
	// ==========
	// falling edge detect, not level
	initial req_cnt = 4'h0;
	always @(posedge clk) begin
		if (prev_ff && req_b === 1'b0) begin
			req_cnt <= req_cnt + 4'h1;
		end
		prev_ff <= (req_b !== 1'b0); // undriven level counts as idle high
	end
endmodule : mcrg_sys_rst_ctl

// [tb/test_mcrg_top.sv]
// self-checking bench for mcrg_top
// assumes the checker is bound and the partner counts requests
`timescale 1ns/1ns
`include "mcrg_cfg.svh"
module test_mcrg_top;
	import mcrg_pkg::*;
	logic clk, rst_b, soft_b, half, sys_en, full_en, half_en, user_b, req_b;
	mcrg_rate_e rate;
	logic [3:0] req_cnt;
	int fail_count, cmp_count;
	// ==========
	// clock, design and partner
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	mcrg_top #(.LOCK_CYCLES(8)) u_dut (.SYS_CLK(clk), .RST_B(rst_b), .SOFT_RST_B(soft_b),
		.HALF_RATE_MODE(half), .SYS_CLK_EN(sys_en), .AUX_FULL_EN(full_en),
		.AUX_HALF_EN(half_en), .USER_RST_B(user_b), .RESET_REQ_B(req_b), .RATE_MODE(rate));
	mcrg_sys_rst_ctl u_ctl (.clk(clk), .req_b(req_b), .req_cnt(req_cnt));
	// ==========
	// helpers
	task conclude;
		if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task wait_for(input logic sel, input logic lvl);
		for (int i = 0; i < 200; i++) begin
			if ((sel ? user_b : req_b) === lvl) return;
			cyc(1);
		end
		fail_count++;
		$display("unexpected at %0t: timeout", $time);
		conclude();
	endtask : wait_for
	// ==========
	// scenarios
	task t_lock;
		chk(req_b, 0);
		wait_for(0, 1'b1);
		chk(user_b, 0);
		wait_for(1, 1'b1);
		chk(rate, RATE_HALF);
	endtask : t_lock
	task t_clocks(input mcrg_rate_e m);
		logic prev;
		prev = half_en;
		chk(rate, m);
		repeat (6) begin
			cyc(1);
			prev = !prev;
			chk(full_en, 1);
			chk(half_en, prev);
			chk(sys_en, m == RATE_HALF ? prev : 1'b1);
		end
	endtask : t_clocks
	task t_soft;
		int n;
		half = 1'b0;
		cyc(2);
		chk(rate, RATE_HALF);
		soft_b = 1'b0;
		cyc(3);
		soft_b = 1'b1;
		wait_for(1, 1'b0);
		n = 0;
		while (user_b === 1'b0 && n < 100) begin
			cyc(1);
			n++;
			chk(req_b, 1);
		end
		chk(8'(n), 8'(`MCRG_SOFT_CYCLES + 3));
	endtask : t_soft
	task t_soft_again;
		int n;
		soft_b = 1'b0;
		cyc(3);
		soft_b = 1'b1;
		wait_for(1, 1'b0);
		cyc(5);
		chk(user_b, 0);
		soft_b = 1'b0;
		cyc(3);
		soft_b = 1'b1;
		n = 0;
		while (user_b === 1'b0 && n < 100) begin
			cyc(1);
			n++;
		end
		chk(8'(n), 8'(`MCRG_SOFT_CYCLES + 3));
	endtask : t_soft_again
	task t_glob;
		rst_b = 1'b0;
		#1;
		chk({user_b, req_b, full_en}, 0);
		cyc(20);
		rst_b = 1'b1;
		wait_for(1, 1'b1);
		chk(req_cnt, 2);
	endtask : t_glob
	// ==========
	// main sequence
	initial begin
		rst_b = 1'b0;
		soft_b = 1'b1;
		half = 1'b1;
		fail_count = 0;
		cmp_count = 0;
		cyc(20);
		rst_b = 1'b1;
		t_lock;
		t_clocks(RATE_HALF);
		t_soft;
		t_clocks(RATE_FULL);
		t_soft_again;
		t_glob;
		conclude;
	end
endmodule : test_mcrg_top
